// file: src/fos_regs.vh
// Register offsets, field positions and timing counts for the flash status host controller
`ifndef FOS_REGS_VH
`define FOS_REGS_VH
// ****************************************
// Host-side register map (AXI4-Lite byte addresses)
// ****************************************
`define FOS_CTRL_OFF 8'h00
`define FOS_ADDR_OFF 8'h04
`define FOS_WDATA_OFF 8'h08
`define FOS_RESULT_OFF 8'h0C
`define FOS_STAT_OFF 8'h10
// Control fields
`define FOS_CTRL_GO 0
`define FOS_CTRL_OP_LO 1
`define FOS_CTRL_OP_HI 3
// Operation codes
`define FOS_OP_WRITE 3'd0
`define FOS_OP_READ 3'd1
`define FOS_OP_SR_READ 3'd2
`define FOS_OP_POLL 3'd3
// Flash-side status register fields
`define FOS_SR_READY 7
`define FOS_SR_ERASE_PAUSED 6
`define FOS_SR_ERASE_FAIL 5
`define FOS_SR_PROG_FAIL 4
`define FOS_SR_BUF_ABORT 3
`define FOS_SR_PROG_PAUSED 2
`define FOS_SR_LOCK_FAIL 1
`define FOS_SR_VALID_MASK 16'h00FE
// Polling word fields
`define FOS_PW_POLL 7
`define FOS_PW_TOG1 6
`define FOS_PW_TIMEOUT 5
`define FOS_PW_ERASE_TMR 3
`define FOS_PW_TOG2 2
`define FOS_PW_ABORT 1
`define FOS_PW_VALID_MASK 16'h00EE
// Status register read command and its address
`define FOS_CMD_SR_READ 16'h0070
`define FOS_CMD_SR_ADDR 24'h00_0555
// Bus cycle timing
`define FOS_STROBE_NS 100
`define FOS_GAP_NS 40
`define FOS_CLK_NS 20
`define FOS_STROBE_CYC ((`FOS_STROBE_NS + `FOS_CLK_NS - 1) / `FOS_CLK_NS)
`define FOS_GAP_CYC ((`FOS_GAP_NS + `FOS_CLK_NS - 1) / `FOS_CLK_NS)
`endif

// file: src/fos_bus_cycle.v
// One asynchronous read or write cycle on the flash parallel pins
`timescale 1ns/10ps
`include "fos_regs.vh"
module fos_bus_cycle #(
  parameter ADDR_W = 24,
  parameter STROBE_CYC = `FOS_STROBE_CYC,
  parameter GAP_CYC = `FOS_GAP_CYC
) (
  input wire mclk,
  input wire reset_n,
  input wire start,
  input wire is_write,
  input wire [ADDR_W-1:0] addr,
  input wire [15:0] wdata,
  output wire done,
  output reg [15:0] rdata_ff,
  output reg [ADDR_W-1:0] fl_addr_ff,
  output reg fl_ce_n_ff,
  output reg fl_oe_n_ff,
  output reg fl_we_n_ff,
  input wire [15:0] fl_dq_in,
  output reg [15:0] fl_dq_out_ff,
  output reg fl_dq_oe_ff
);
  localparam ST_IDLE = 2'd0;
  localparam ST_STROBE = 2'd1;
  localparam ST_GAP = 2'd2;
  reg [1:0] state_ff;
  reg [7:0] cnt_ff;
  reg wr_ff;
  // ****************************************
  // Strobe sequencer
  // ****************************************
  // Each read is framed by its own chip-select pulse so the device sees a distinct cycle
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      fl_addr_ff <= {ADDR_W{1'b0}};
      fl_ce_n_ff <= 1'b1;
      fl_oe_n_ff <= 1'b1;
      fl_we_n_ff <= 1'b1;
      fl_dq_out_ff <= 16'h0000;
      fl_dq_oe_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_STROBE;
            cnt_ff <= STROBE_CYC[7:0];
            wr_ff <= is_write;
            fl_addr_ff <= addr;
            fl_ce_n_ff <= 1'b0;
            fl_oe_n_ff <= is_write;
            fl_we_n_ff <= ~is_write;
            fl_dq_out_ff <= wdata;
            fl_dq_oe_ff <= is_write;
          end
        end
        ST_STROBE: begin
          if (cnt_ff == 8'h01) begin
            // Data sampled at end of strobe; write latches on rising strobe
            if (!wr_ff) rdata_ff <= fl_dq_in;
            fl_ce_n_ff <= 1'b1;
            fl_oe_n_ff <= 1'b1;
            fl_we_n_ff <= 1'b1;
            state_ff <= ST_GAP;
            cnt_ff <= GAP_CYC[7:0];
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        ST_GAP: begin
          fl_dq_oe_ff <= 1'b0;
          if (cnt_ff == 8'h01) state_ff <= ST_IDLE;
          else cnt_ff <= cnt_ff - 8'h01;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
  assign done = (state_ff == ST_GAP) && (cnt_ff == 8'h01);
endmodule

// file: src/fos_host.v
// Host controller that reads flash status over the parallel pins, driven over AXI4-Lite
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "fos_regs.vh"
module fos_host #(
  parameter ADDR_W = 24
) (
  input wire mclk,
  input wire reset_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire [ADDR_W-1:0] fl_addr,
  output wire fl_ce_n,
  output wire fl_oe_n,
  output wire fl_we_n,
  input wire [15:0] fl_dq_in,
  output wire [15:0] fl_dq_out,
  output wire fl_dq_oe
);
  localparam ST_IDLE = 3'd0;
  localparam ST_CYC = 3'd1;
  localparam ST_SR_CMD = 3'd2;
  localparam ST_SR_RD = 3'd3;
  localparam ST_POLL_A = 3'd4;
  localparam ST_POLL_B = 3'd5;
  localparam ST_POLL_C = 3'd6;
  reg [2:0] state_ff;
  reg [2:0] op_ff;
  reg [ADDR_W-1:0] addr_ff;
  reg [15:0] wdata_ff;
  reg [15:0] result_ff;
  reg [15:0] first_ff;
  reg busy_ff;
  reg done_ff;
  reg busy_alg_ff;
  reg toggling_ff;
  reg timeout_ff;
  reg abort_ff;
  reg erase_begun_ff;
  reg erase_sector_ff;
  reg stat_valid_ff;
  reg [7:0] sr_flags_ff;
  reg aw_ok_ff;
  reg w_ok_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wbuf_ff;
  reg cyc_start;
  reg cyc_write;
  reg [ADDR_W-1:0] cyc_addr;
  reg [15:0] cyc_wdata;
  reg cyc_sent_ff;
  wire cyc_done;
  wire [15:0] cyc_rdata;
  wire go_write;

  // Masks out reserved and undefined bits of a status or polling read
  function [15:0] fos_mask;
    input [15:0] raw;
    input [15:0] keep;
    begin
      fos_mask = raw & keep;
    end
  endfunction
  wire [15:0] sr_masked = fos_mask(cyc_rdata, `FOS_SR_VALID_MASK);

  // ****************************************
  // Flash pin cycle engine
  // ****************************************
  fos_bus_cycle #(
    .ADDR_W(ADDR_W)
  ) u_cycle (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata_ff(cyc_rdata),
    .fl_addr_ff(fl_addr),
    .fl_ce_n_ff(fl_ce_n),
    .fl_oe_n_ff(fl_oe_n),
    .fl_we_n_ff(fl_we_n),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out_ff(fl_dq_out),
    .fl_dq_oe_ff(fl_dq_oe)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign go_write = aw_ok_ff && w_ok_ff && !s_axi_bvalid;

  // Address and data captured in either order; response once both held
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wbuf_ff <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_ff <= 1'b1;
        wbuf_ff <= s_axi_wdata;
      end
      if (go_write) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_ff == `FOS_CTRL_OFF || awaddr_ff == `FOS_ADDR_OFF ||
                        awaddr_ff == `FOS_WDATA_OFF) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data from a register snapshot one cycle after the address is taken
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `FOS_CTRL_OFF: s_axi_rdata <= {28'h000_0000, op_ff, busy_ff};
        `FOS_ADDR_OFF: s_axi_rdata <= {{(32-ADDR_W){1'b0}}, addr_ff};
        `FOS_WDATA_OFF: s_axi_rdata <= {16'h0000, wdata_ff};
        `FOS_RESULT_OFF: s_axi_rdata <= {16'h0000, result_ff};
        `FOS_STAT_OFF: s_axi_rdata <= {16'h0000, sr_flags_ff, stat_valid_ff, erase_sector_ff,
                                      erase_begun_ff, abort_ff, timeout_ff, toggling_ff,
                                      busy_alg_ff, done_ff};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Cycle request decode
  // ****************************************
  // Status read issues the command then one read; polling issues three reads
  always @* begin
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = addr_ff;
    cyc_wdata = wdata_ff;
    case (state_ff)
      ST_CYC: begin
        cyc_start = !cyc_sent_ff;
        cyc_write = (op_ff == `FOS_OP_WRITE);
      end
      ST_SR_CMD: begin
        cyc_start = !cyc_sent_ff;
        cyc_write = 1'b1;
        cyc_addr = `FOS_CMD_SR_ADDR;
        cyc_wdata = `FOS_CMD_SR_READ;
      end
      ST_SR_RD, ST_POLL_A, ST_POLL_B, ST_POLL_C: cyc_start = !cyc_sent_ff;
      default: cyc_start = 1'b0;
    endcase
  end

  // Cycle already launched in this state; cleared on each state step
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cyc_sent_ff <= 1'b0;
    else if (cyc_done) cyc_sent_ff <= 1'b0;
    else if (cyc_start) cyc_sent_ff <= 1'b1;
  end

  // ****************************************
  // Operation sequencer
  // ****************************************
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      op_ff <= `FOS_OP_WRITE;
      addr_ff <= {ADDR_W{1'b0}};
      wdata_ff <= 16'h0000;
      result_ff <= 16'h0000;
      first_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      busy_alg_ff <= 1'b0;
      toggling_ff <= 1'b0;
      timeout_ff <= 1'b0;
      abort_ff <= 1'b0;
      erase_begun_ff <= 1'b0;
      erase_sector_ff <= 1'b0;
      stat_valid_ff <= 1'b0;
      sr_flags_ff <= 8'h00;
    end else begin
      if (go_write && state_ff == ST_IDLE) begin
        if (awaddr_ff == `FOS_ADDR_OFF) addr_ff <= wbuf_ff[ADDR_W-1:0];
        if (awaddr_ff == `FOS_WDATA_OFF) wdata_ff <= wbuf_ff[15:0];
        if (awaddr_ff == `FOS_CTRL_OFF && wbuf_ff[`FOS_CTRL_GO]) begin
          op_ff <= wbuf_ff[`FOS_CTRL_OP_HI:`FOS_CTRL_OP_LO];
          busy_ff <= 1'b1;
          done_ff <= 1'b0;
          case (wbuf_ff[`FOS_CTRL_OP_HI:`FOS_CTRL_OP_LO])
            `FOS_OP_SR_READ: state_ff <= ST_SR_CMD;
            `FOS_OP_POLL: state_ff <= ST_POLL_A;
            default: state_ff <= ST_CYC;
          endcase
        end
      end
      case (state_ff)
        ST_CYC: if (cyc_done) begin
          result_ff <= cyc_rdata;
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        ST_SR_CMD: if (cyc_done) state_ff <= ST_SR_RD;
        ST_SR_RD: if (cyc_done) begin
          result_ff <= sr_masked;
          // Suspend is only settled once ready reads one; flags kept only then
          stat_valid_ff <= cyc_rdata[`FOS_SR_READY];
          if (cyc_rdata[`FOS_SR_READY]) sr_flags_ff <= sr_masked[7:0];
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        // Two back-to-back reads reveal toggling; third rechecks the toggle bit and samples timeout and abort
        ST_POLL_A: if (cyc_done) begin
          first_ff <= fos_mask(cyc_rdata, `FOS_PW_VALID_MASK);
          state_ff <= ST_POLL_B;
        end
        ST_POLL_B: if (cyc_done) begin
          toggling_ff <= first_ff[`FOS_PW_TOG1] ^ cyc_rdata[`FOS_PW_TOG1];
          erase_sector_ff <= first_ff[`FOS_PW_TOG2] ^ cyc_rdata[`FOS_PW_TOG2];
          erase_begun_ff <= cyc_rdata[`FOS_PW_ERASE_TMR];
          first_ff <= fos_mask(cyc_rdata, `FOS_PW_VALID_MASK); // Second read kept for the recheck
          state_ff <= ST_POLL_C;
        end
        ST_POLL_C: if (cyc_done) begin
          // Final reread: poll bit may settle with timeout, data after poll turns true
          result_ff <= cyc_rdata;
          busy_alg_ff <= toggling_ff &&
                         (cyc_rdata[`FOS_PW_TOG1] != first_ff[`FOS_PW_TOG1]);
          timeout_ff <= cyc_rdata[`FOS_PW_TIMEOUT] && toggling_ff;
          abort_ff <= cyc_rdata[`FOS_PW_ABORT] && toggling_ff;
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          state_ff <= ST_IDLE;
        end
        default: ;
      endcase
    end
  end
endmodule

// file: bench/fos_host_chk.sv
// Concurrent checks on the ports of the flash status host controller
`timescale 1ns/10ps
module fos_host_chk (
  input wire mclk,
  input wire reset_n,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  input wire fl_dq_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Flash strobe shapes
  // ****************************************
  // A strobe stays low five cycles, then lets go
  sequence low5(sig);
    !sig [*5] ##1 sig;
  endsequence
  // Chip select rests two cycles between cycles
  sequence gap2;
    fl_ce_n [*2];
  endsequence
  read_width_a: assert property ($fell(fl_oe_n) |-> low5(fl_oe_n)) else $error("read strobe width");
  write_width_a: assert property ($fell(fl_we_n) |-> low5(fl_we_n)) else $error("write strobe width");
  cycle_gap_a: assert property ($rose(fl_ce_n) |-> gap2) else $error("gap too short");
  read_frame_a: assert property (!fl_oe_n |-> !fl_ce_n && fl_we_n && !fl_dq_oe) else $error("read framing");
  // ****************************************
  // Register bus answers
  // ****************************************
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read answer");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer dropped");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
endmodule

// file: bench/fos_flash_model.sv
// Behavioural flash device answering status and polling reads
`timescale 1ns/10ps
module fos_flash_model (
  input wire reset_n,
  input wire [23:0] fl_addr,
  input wire fl_ce_n,
  input wire fl_oe_n,
  input wire fl_we_n,
  input wire [15:0] fl_dq_out,
  input wire fl_dq_oe,
  output wire [15:0] fl_dq_in,
  input wire [15:0] sr_val,
  input wire alg,
  input wire susp,
  input wire erasing,
  input wire tmo_bit,
  input wire abrt_bit,
  input wire etmr,
  input wire [7:0] esec
);
  reg tog1_ff, tog2_ff, set_ff, clr_ff, pdat_ff;
  reg [15:0] last_ff;
  wire rd = !fl_ce_n && !fl_oe_n;
  // Reserved bits flip so the host cannot lean on them
  wire [15:0] poll_w = {~last_ff[15:8], (erasing ? susp : ~pdat_ff), tog1_ff, tmo_bit, ~last_ff[4], etmr,
    tog2_ff, abrt_bit, ~last_ff[0]};
  wire [15:0] word = (set_ff ^ clr_ff) ? sr_val : alg ? poll_w : ~fl_addr[15:0];
  // Released bus shows the inverse of the last value, not a held copy
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : rd ? word : ~last_ff;
  // Status read command latched at the end of its write strobe
  always @(posedge fl_we_n or negedge reset_n) begin
    if (!reset_n) begin
      set_ff <= 1'h0;
      pdat_ff <= 1'h0;
    end else begin
      // Bit 7 of the last word written stands for the programmed datum
      pdat_ff <= fl_dq_out[7];
      if (fl_dq_out == 16'h0070 && fl_addr == 24'h00_0555) set_ff <= ~clr_ff;
    end
  end
  // Snapshot of the word shown by the current read
  always @(negedge fl_oe_n or negedge reset_n) begin
    if (!reset_n) last_ff <= 16'h0000;
    else last_ff <= word;
  end
  // Toggles advance (tog1 while alg and not susp, tog2 on reads of sector esec while erasing) and the overlay closes as each read ends
  always @(posedge fl_oe_n or negedge reset_n) begin
    if (!reset_n) begin
      tog1_ff <= 1'h0;
      tog2_ff <= 1'h0;
      clr_ff <= 1'h0;
    end else begin
      if (alg && !susp) tog1_ff <= ~tog1_ff;
      if (erasing && fl_addr[23:16] == esec) tog2_ff <= ~tog2_ff;
      clr_ff <= set_ff;
    end
  end
endmodule

// file: bench/fos_host_test.sv
// Testbench for the flash status host controller with a device model
`timescale 1ns/10ps
`include "fos_regs.vh"
`define FOS_CHK(g, e) begin comparisons = comparisons + 1; if ((g) !== (e)) begin n_mismatch = n_mismatch + 1; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module fos_host_test;
  localparam [48:0] MODES = {7'h00, 7'h44, 7'h48, 7'h52, 7'h71, 7'h53, 7'h40};
  localparam [63:0] SRS = {16'h00BE, 16'h5A81, 16'h0F7E, 16'hA5FF};
  reg mclk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg alg, susp, erasing, tmo_bit, abrt_bit, etmr;
  reg [7:0] s_axi_awaddr, s_axi_araddr, esec;
  reg [31:0] s_axi_wdata, rd, stat;
  reg [3:0] s_axi_wstrb;
  reg [1:0] resp;
  reg [15:0] sr_val;
  reg [8:0] ex;
  reg [6:0] m;
  integer n_mismatch, comparisons, i;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [23:0] fl_addr;
  wire [15:0] fl_dq_in, fl_dq_out;
  // 50 MHz clock
  always #10 mclk = ~mclk;
  fos_host #(.ADDR_W(24)) uut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
  fos_flash_model model (.reset_n(reset_n), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .sr_val(sr_val),
    .alg(alg), .susp(susp), .erasing(erasing), .tmo_bit(tmo_bit), .abrt_bit(abrt_bit), .etmr(etmr), .esec(esec));
  // Verdict and end of run
  task summarize;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Bus write: address and data offered together, each released when taken
  task axw(input [7:0] a, input [31:0] d);
    integer k;
    reg pa, pw, pb;
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      pa = 1'h1;
      pw = 1'h1;
      pb = 1'h1;
      for (k = 0; k < 200 && pb; k = k + 1) begin
        @(posedge mclk);
        if (pa && s_axi_awready) begin
          pa = 1'h0;
          s_axi_awvalid <= 1'h0;
        end
        if (pw && s_axi_wready) begin
          pw = 1'h0;
          s_axi_wvalid <= 1'h0;
        end
        if (s_axi_bvalid) begin
          pb = 1'h0;
          resp = s_axi_bresp;
          s_axi_bready <= 1'h0;
        end
      end
      if (pb) begin
        n_mismatch = n_mismatch + 1;
        summarize;
      end
    end
  endtask
  // Bus read: answer taken at the edge where rvalid is seen
  task axr(input [7:0] a);
    integer k;
    reg pa, pr;
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      pa = 1'h1;
      pr = 1'h1;
      for (k = 0; k < 200 && pr; k = k + 1) begin
        @(posedge mclk);
        if (pa && s_axi_arready) begin
          pa = 1'h0;
          s_axi_arvalid <= 1'h0;
        end
        if (s_axi_rvalid) begin
          pr = 1'h0;
          rd = s_axi_rdata;
          resp = s_axi_rresp;
          s_axi_rready <= 1'h0;
        end
      end
      if (pr) begin
        n_mismatch = n_mismatch + 1;
        summarize;
      end
    end
  endtask
  // One flash operation, waited out through the busy flag, status left in stat
  task op(input [2:0] code, input [23:0] fa, input [15:0] d);
    integer k;
    begin
      axw(`FOS_ADDR_OFF, {8'h00, fa});
      axw(`FOS_WDATA_OFF, {16'h0000, d});
      axw(`FOS_CTRL_OFF, {28'h000_0000, code, 1'h1});
      rd = 32'h0000_0001;
      for (k = 0; k < 100 && rd[0]; k = k + 1) axr(`FOS_CTRL_OFF);
      if (rd[0]) begin
        n_mismatch = n_mismatch + 1;
        summarize;
      end
      axr(`FOS_STAT_OFF);
      stat = rd;
    end
  endtask
  // Main sequence
  initial begin
    {mclk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {alg, susp, erasing, tmo_bit, abrt_bit, etmr} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0_0000_0000_000F;
    {sr_val, esec, n_mismatch, comparisons} = 88'h0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'h1;
    axr(`FOS_STAT_OFF);
    `FOS_CHK(rd, 32'h0000_0000)
    axr(8'h20);
    `FOS_CHK({resp, rd}, 34'h2_0000_0000)
    axw(8'h24, 32'h0000_0000);
    `FOS_CHK(resp, 2'h2)
    // Status register reads: flags kept only when ready
    ex = 9'h000;
    for (i = 0; i < 4; i = i + 1) begin
      sr_val <= SRS[i*16 +: 16];
      op(`FOS_OP_SR_READ, 24'h00_0000, 16'h0000);
      ex = SRS[i*16+7] ? {SRS[i*16 +: 8] & 8'hFE, 1'h1} : {ex[8:1], 1'h0};
      `FOS_CHK(stat[15:7], ex)
    end
    // Command write opens the overlay for one read only
    sr_val <= 16'h3C96;
    op(`FOS_OP_WRITE, 24'h00_0555, 16'h0070);
    op(`FOS_OP_READ, 24'h00_1000, 16'h0000);
    axr(`FOS_RESULT_OFF);
    `FOS_CHK(rd[15:0], 16'h3C96)
    op(`FOS_OP_READ, 24'h00_1000, 16'h0000);
    axr(`FOS_RESULT_OFF);
    `FOS_CHK(rd[15:0], 16'hEFFF)
    // Polling across algorithm states
    esec <= 8'h01;
    for (i = 0; i < 7; i = i + 1) begin
      m = MODES[i*7 +: 7];
      {alg, susp, erasing, tmo_bit, abrt_bit, etmr} <= m[6:1];
      op(`FOS_OP_POLL, m[0] ? 24'h01_FFFF : 24'h02_FFFF, 16'h0000);
      `FOS_CHK(stat[6:2], {m[4] & m[0], m[1], m[2], m[3], m[6] & !m[5]})
      `FOS_CHK(stat[1:0], {m[6] & !m[5], 1'h1})
    end
    summarize;
  end
endmodule
bind fos_host fos_host_chk u_chk (.mclk(mclk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n), .fl_dq_oe(fl_dq_oe));
